// ### logic/pin_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_s;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            sync_s q;
            sync_s next_q;

            // R15: two flops
            always_comb
            begin
                next_q.meta   = i_async[g];
                next_q.stable = q.meta;
            end

            // Reset to low: reads as torque off until the pin settles
            always_ff @(posedge i_mclk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                    q <= '0;
                else
                    q <= next_q;
            end

            assign o_sync[g] = q.stable;
        end
    endgenerate

endmodule : pin_sync

// ### logic/sto_monitor.sv
// Safe torque-off supervision: supply cut, gate gating, monitor, self-test.
// Assumes an APB master on i_mclk and pin inputs asynchronous to it.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sto_monitor #(
    parameter int MS_CYCLES = sto_pkg::MS_CYCLES,
    parameter int N_GATES   = 6,
    parameter int N_DOUT    = 8
) (
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    input  wire sto_pkg::apb_req_s  i_apb,
    output sto_pkg::apb_rsp_s       o_apb,
    input  wire logic               i_torque_off_input_a,
    input  wire logic               i_torque_off_input_b,
    input  wire logic               i_general_input_1,
    input  wire logic               i_general_input_2,
    input  wire logic               i_driver_supply_ok,
    input  wire logic               i_voltage_fault,
    input  wire logic               i_trip_restored,
    input  wire logic               i_script_selftest,
    input  wire logic [N_GATES-1:0] i_pwm_gates,
    output logic                    o_driver_supply_en,
    output logic      [N_GATES-1:0] o_gates,
    output logic      [N_DOUT-1:0]  o_fault_dout,
    output logic                    o_status_led,
    output logic                    o_trip_retained
);

    localparam logic [19:0] MS_LAST      = 20'(MS_CYCLES - 1);
    localparam logic [7:0]  CUT_LAST     = 8'(sto_pkg::SELFTEST_CUT_MS - 1);
    localparam logic [7:0]  RESTORE_LAST = 8'(sto_pkg::SELFTEST_RESTORE_MS - 1);
    localparam logic [7:0]  LED_LAST     = 8'(sto_pkg::LED_STEP_MS - 1);

    generate
        if (MS_CYCLES < 2 || MS_CYCLES > 1048576)
        begin : g_bad_ms
            $error("MS_CYCLES outside 2 to 2**20");
        end
        if (N_DOUT < 2 || N_DOUT > 8)
        begin : g_bad_dout
            $error("N_DOUT outside 2 to 8");
        end
        if (N_GATES < 1 || N_GATES > 32)
        begin : g_bad_gates
            $error("N_GATES outside 1 to 32");
        end
    endgenerate

    typedef struct packed {
        logic [19:0]          ms_cnt;
        logic                 tick;
        sto_pkg::selftest_e   st;
        logic [7:0]           st_ms;
        logic                 monitor_en;
        logic                 out_en;
        logic [2:0]           out_sel;
        logic                 use_general;
        logic                 running;
        logic                 sto_fault;
        logic                 st_fail;
        logic                 mismatch;
        logic                 trip;
        logic                 boot;
        logic                 prev_low;
        logic                 prev_mis;
        logic [7:0]           led_ms;
        logic [2:0]           led_step;
        logic                 led;
        logic                 supply_en;
        logic [N_GATES-1:0]   gates;
        logic [N_DOUT-1:0]    dout;
        sto_pkg::apb_rsp_s    apb;
    } state_s;

    state_s q;
    state_s next_q;

    logic [sto_pkg::PIN_COUNT-1:0] pins_async;
    logic [sto_pkg::PIN_COUNT-1:0] pins;
    logic                          in_a;
    logic                          in_b;
    logic                          both_high;
    logic                          supply_ok;

    assign pins_async[sto_pkg::PIN_A]       = i_torque_off_input_a;
    assign pins_async[sto_pkg::PIN_B]       = i_torque_off_input_b;
    assign pins_async[sto_pkg::PIN_GEN1]    = i_general_input_1;
    assign pins_async[sto_pkg::PIN_GEN2]    = i_general_input_2;
    assign pins_async[sto_pkg::PIN_SUPPLY]  = i_driver_supply_ok;
    assign pins_async[sto_pkg::PIN_VFAULT]  = i_voltage_fault;
    assign pins_async[sto_pkg::PIN_RESTORE] = i_trip_restored;

    // R15: pin synchroniser
    pin_sync #(
        .WIDTH (sto_pkg::PIN_COUNT)
    ) u_pin_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   (pins_async),
        .o_sync    (pins)
    );

    // R13: general input fallback
    assign in_a      = q.use_general ? pins[sto_pkg::PIN_GEN1] : pins[sto_pkg::PIN_A];
    assign in_b      = q.use_general ? pins[sto_pkg::PIN_GEN2] : pins[sto_pkg::PIN_B];
    // R1: both inputs high
    assign both_high = in_a & in_b;
    assign supply_ok = pins[sto_pkg::PIN_SUPPLY];

    logic        setup;
    logic        access;
    logic        hit;
    logic [31:0] rdata;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        start_cmd;
    logic        selftest_cmd;
    logic        clear_cmd;
    logic        selftest_req;
    logic        any_fault;
    logic        show_fault;

    always_comb
    begin
        setup  = i_apb.psel & ~i_apb.penable;
        access = i_apb.psel & i_apb.penable & q.apb.pready;
        hit    = (i_apb.paddr == sto_pkg::CTRL_OFFSET)
               | (i_apb.paddr == sto_pkg::CONFIG_OFFSET)
               | (i_apb.paddr == sto_pkg::STATUS_OFFSET);
        rdata  = 32'h0;
        unique case (i_apb.paddr)
            sto_pkg::CTRL_OFFSET:
                rdata[sto_pkg::CTRL_MONITOR_BIT] = q.monitor_en;
            sto_pkg::CONFIG_OFFSET:
            begin
                rdata[sto_pkg::CFG_OUT_EN_BIT]                        = q.out_en;
                rdata[sto_pkg::CFG_OUT_SEL_LSB+2:sto_pkg::CFG_OUT_SEL_LSB] = q.out_sel;
                rdata[sto_pkg::CFG_GENERAL_BIT]                       = q.use_general;
            end
            sto_pkg::STATUS_OFFSET:
            begin
                rdata[sto_pkg::STAT_INPUTS_OK_BIT] = both_high;
                rdata[sto_pkg::STAT_RUNNING_BIT]   = q.running;
                rdata[sto_pkg::STAT_STO_FAULT_BIT] = q.sto_fault;
                rdata[sto_pkg::STAT_ST_FAIL_BIT]   = q.st_fail;
                rdata[sto_pkg::STAT_MISMATCH_BIT]  = q.mismatch;
                rdata[sto_pkg::STAT_TRIP_BIT]      = q.trip;
                rdata[sto_pkg::STAT_ST_BUSY_BIT]   = (q.st != sto_pkg::ST_IDLE);
                rdata[sto_pkg::STAT_SUPPLY_BIT]    = supply_ok;
                rdata[sto_pkg::STAT_INPUT_A_BIT]   = in_a;
                rdata[sto_pkg::STAT_INPUT_B_BIT]   = in_b;
            end
            default:
                rdata = 32'h0;
        endcase
        wr_ctrl      = access & i_apb.pwrite & (i_apb.paddr == sto_pkg::CTRL_OFFSET);
        wr_cfg       = access & i_apb.pwrite & (i_apb.paddr == sto_pkg::CONFIG_OFFSET);
        start_cmd    = wr_ctrl & i_apb.pwdata[sto_pkg::CTRL_START_BIT];
        selftest_cmd = wr_ctrl & i_apb.pwdata[sto_pkg::CTRL_SELFTEST_BIT];
        clear_cmd    = wr_ctrl & i_apb.pwdata[sto_pkg::CTRL_CLEAR_BIT];
        // R9: command or script request
        selftest_req = selftest_cmd | i_script_selftest;
    end

    always_comb
    begin
        next_q = q;

        // Millisecond enable
        next_q.tick = 1'b0;
        if (q.ms_cnt == MS_LAST)
        begin
            next_q.ms_cnt = 20'h0;
            next_q.tick   = 1'b1;
        end
        else
            next_q.ms_cnt = q.ms_cnt + 20'h1;

        // Zero-wait slave: answer lands in the first access cycle
        next_q.apb.pready  = setup;
        next_q.apb.prdata  = setup ? rdata : 32'h0;
        next_q.apb.pslverr = setup & ~hit;

        if (wr_ctrl)
            // R4: monitor enable
            next_q.monitor_en = i_apb.pwdata[sto_pkg::CTRL_MONITOR_BIT];
        if (wr_cfg)
        begin
            next_q.out_en      = i_apb.pwdata[sto_pkg::CFG_OUT_EN_BIT];
            next_q.out_sel     = i_apb.pwdata[sto_pkg::CFG_OUT_SEL_LSB+2:sto_pkg::CFG_OUT_SEL_LSB];
            next_q.use_general = i_apb.pwdata[sto_pkg::CFG_GENERAL_BIT];
        end

        // Clear first so a fault raised in the same cycle survives
        if (clear_cmd)
        begin
            next_q.sto_fault = 1'b0;
            next_q.st_fail   = 1'b0;
            next_q.mismatch  = 1'b0;
        end

        // R9: self-test sequence, reset lands in ST_CUT for power-on
        unique case (q.st)
            sto_pkg::ST_IDLE:
                if (selftest_req)
                begin
                    next_q.st    = sto_pkg::ST_CUT;
                    next_q.st_ms = 8'h0;
                end
            sto_pkg::ST_CUT:
                if (q.tick)
                begin
                    if (q.st_ms == CUT_LAST)
                    begin
                        // R10: supply failed to drop
                        if (supply_ok)
                            next_q.st_fail = 1'b1;
                        next_q.st    = sto_pkg::ST_RESTORE;
                        next_q.st_ms = 8'h0;
                    end
                    else
                        next_q.st_ms = q.st_ms + 8'h1;
                end
            sto_pkg::ST_RESTORE:
                if (q.tick)
                begin
                    if (q.st_ms == RESTORE_LAST)
                    begin
                        // R10: supply failed to return
                        if (both_high & ~supply_ok)
                            next_q.st_fail = 1'b1;
                        next_q.st = sto_pkg::ST_IDLE;
                    end
                    else
                        next_q.st_ms = q.st_ms + 8'h1;
                end
            default:
                next_q.st = sto_pkg::ST_IDLE;
        endcase

        // R7: millisecond sampling
        if (q.tick)
        begin
            next_q.prev_low = ~both_high;
            next_q.prev_mis = in_a ^ in_b;
            // One tick of grace lets the supply fall before a fault counts
            if (q.monitor_en & ~both_high & q.prev_low & supply_ok & (q.st == sto_pkg::ST_IDLE))
                next_q.sto_fault = 1'b1;
            // R11: lasting mismatch
            if (q.monitor_en & (in_a ^ in_b) & q.prev_mis)
                next_q.mismatch = 1'b1;
        end

        any_fault = next_q.sto_fault | next_q.st_fail | next_q.mismatch;

        // R6: fresh start needed
        if (start_cmd & both_high & ~any_fault & (q.st == sto_pkg::ST_IDLE) & ~selftest_req)
        begin
            next_q.running = 1'b1;
            next_q.trip    = 1'b0;
        end
        // R5: immediate stop
        if (~both_high | next_q.st_fail | (next_q.st != sto_pkg::ST_IDLE))
            next_q.running = 1'b0;

        // R14: trip retention; synced pins read low for two cycles after reset, so only the retained pin counts then
        if (~both_high & ~(q.boot & (q.ms_cnt < 20'h2)))
            next_q.trip = 1'b1;
        if (q.boot & pins[sto_pkg::PIN_RESTORE])
            next_q.trip = 1'b1;
        if (q.boot & q.tick)
            next_q.boot = 1'b0;

        // R2: supply cut
        next_q.supply_en = both_high & (next_q.st != sto_pkg::ST_CUT);
        // R3: gates overridden
        if (next_q.running & next_q.supply_en & ~next_q.st_fail)
            next_q.gates = i_pwm_gates;
        else
            next_q.gates = '0;

        // R8: fault output
        next_q.dout = '0;
        for (int k = 0; k < N_DOUT; k++)
            if (q.out_en & any_fault & (q.out_sel == 3'(k)))
                next_q.dout[k] = 1'b1;

        // R12: shared blink pattern
        show_fault = next_q.sto_fault | next_q.mismatch | next_q.st_fail | pins[sto_pkg::PIN_VFAULT];
        if (q.tick)
        begin
            if (q.led_ms == LED_LAST)
            begin
                next_q.led_ms   = 8'h0;
                next_q.led_step = q.led_step + 3'h1;
            end
            else
                next_q.led_ms = q.led_ms + 8'h1;
        end
        next_q.led = show_fault ? sto_pkg::LED_FAULT_PATTERN[q.led_step] : 1'b1;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            q             <= '0;
            q.st          <= sto_pkg::ST_CUT;
            q.boot        <= 1'b1;
            q.monitor_en  <= sto_pkg::MONITOR_RESET;
            q.out_en      <= sto_pkg::OUT_EN_RESET;
            q.out_sel     <= sto_pkg::OUT_SEL_RESET;
            q.use_general <= sto_pkg::GENERAL_RESET;
        end
        else
            q <= next_q;
    end

    assign o_apb              = q.apb;
    assign o_driver_supply_en = q.supply_en;
    assign o_gates            = q.gates;
    assign o_fault_dout       = q.dout;
    assign o_status_led       = q.led;
    assign o_trip_retained    = q.trip;

endmodule : sto_monitor

// ### shared/sto_pkg.sv
// Constants, carriers and types for the safe torque-off monitor.
// Assumes a 50 MHz logic clock and a 32-bit APB master with 12 address bits.
// Behaviour
// R1: Motor may be driven only while both torque-off inputs are high.
// R2: Either input low removes the gate-driver supply, so no switch turns on.
// R3: Cut path needs no software and overrides the processor gate commands.
// R4: Millisecond monitoring runs only while software has set the enable bit.
// R5: Activation stops torque immediately: running state and gates drop at once.
// R6: After inputs return high, motion resumes only on a new start command.
// R7: Each millisecond, input low with supply still present sets the fault flag; here only if the previous sample was low too and no self-test runs.
// R8: A detected fault may drive a software-selected digital output.
// R9: Self-test runs after power-on, on register command or script request.
// R10: Failed self-test stops the gates, sets a flag, may drive an output.
// R11: Both inputs must always match; lasting mismatch is a circuit fault.
// R12: Status LED shows torque-off faults with the voltage-fault blink pattern.
// R13: Variant without circuit uses general digital inputs one and two.
// R14: Trip state survives power cycles through a retained trip pin.
// R15: All pin inputs pass two synchroniser flops before any logic.
package sto_pkg;

    localparam int CLK_PERIOD_NS       = 20;
    localparam int MS_NS               = 1000000;
    localparam int MS_CYCLES           = MS_NS / CLK_PERIOD_NS;
    localparam int SELFTEST_CUT_MS     = 5;
    localparam int SELFTEST_RESTORE_MS = 5;
    localparam int LED_STEP_MS         = 100;

    localparam logic [7:0]  LED_FAULT_PATTERN = 8'h05;

    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] CONFIG_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    localparam int CTRL_MONITOR_BIT  = 0;
    localparam int CTRL_START_BIT    = 1;
    localparam int CTRL_SELFTEST_BIT = 2;
    localparam int CTRL_CLEAR_BIT    = 3;

    localparam int CFG_OUT_EN_BIT  = 0;
    localparam int CFG_OUT_SEL_LSB = 1;
    localparam int CFG_GENERAL_BIT = 4;

    localparam int STAT_INPUTS_OK_BIT  = 0;
    localparam int STAT_RUNNING_BIT    = 1;
    localparam int STAT_STO_FAULT_BIT  = 2;
    localparam int STAT_ST_FAIL_BIT    = 3;
    localparam int STAT_MISMATCH_BIT   = 4;
    localparam int STAT_TRIP_BIT       = 5;
    localparam int STAT_ST_BUSY_BIT    = 6;
    localparam int STAT_SUPPLY_BIT     = 7;
    localparam int STAT_INPUT_A_BIT    = 8;
    localparam int STAT_INPUT_B_BIT    = 9;

    localparam logic       MONITOR_RESET = 1'b0;
    localparam logic       OUT_EN_RESET  = 1'b0;
    localparam logic [2:0] OUT_SEL_RESET = 3'h0;
    localparam logic       GENERAL_RESET = 1'b0;

    // Index of each bit in the synchronised pin vector
    localparam int PIN_A       = 0;
    localparam int PIN_B       = 1;
    localparam int PIN_GEN1    = 2;
    localparam int PIN_GEN2    = 3;
    localparam int PIN_SUPPLY  = 4;
    localparam int PIN_VFAULT  = 5;
    localparam int PIN_RESTORE = 6;
    localparam int PIN_COUNT   = 7;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_s;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CUT     = 2'b01,
        ST_RESTORE = 2'b11
    } selftest_e;

endpackage : sto_pkg

// ### test/sto_monitor_bench.sv
// Self-checking bench for the torque-off monitor over APB.
// Assumes the partner model drives the switch pins and the supply sense.
`timescale 1ns/100ps
module sto_monitor_bench;
    localparam int          MS   = 20;
    localparam logic [5:0]  PWM  = 6'h2a;
    localparam logic [11:0] CTRL = sto_pkg::CTRL_OFFSET;
    localparam logic [11:0] CFG  = sto_pkg::CONFIG_OFFSET;
    localparam logic [11:0] STAT = sto_pkg::STATUS_OFFSET;
    localparam logic [31:0] MON  = 32'h1 << sto_pkg::CTRL_MONITOR_BIT;
    localparam logic [31:0] GO   = 32'h1 << sto_pkg::CTRL_START_BIT;
    localparam logic [31:0] TEST = 32'h1 << sto_pkg::CTRL_SELFTEST_BIT;
    localparam logic [31:0] CLR  = 32'h1 << sto_pkg::CTRL_CLEAR_BIT;
    localparam int          RUN  = sto_pkg::STAT_RUNNING_BIT;
    localparam int          FLT  = sto_pkg::STAT_STO_FAULT_BIT;
    localparam int          STF  = sto_pkg::STAT_ST_FAIL_BIT;
    localparam int          MIS  = sto_pkg::STAT_MISMATCH_BIT;
    localparam int          BSY  = sto_pkg::STAT_ST_BUSY_BIT;

    logic              i_mclk, i_reset_n, lvl_a, lvl_b, stuck, gen1, gen2, trip_in, script_st;
    logic              in_a, in_b, supply_ok, supply_en, led, trip_out, rd_err;
    logic              sup_seen, led_seen, trip_seen;
    logic [5:0]        gates, gates_seen;
    logic [7:0]        dout, dout_seen;
    logic [31:0]       rd_data;
    sto_pkg::apb_req_s apb_req;
    sto_pkg::apb_rsp_s apb_rsp, rsp_seen;
    int                num_errors = 0;
    int                cmp_count = 0;

    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // Settled copies, taken away from the launching edge
    always @(negedge i_mclk)
    begin
        rsp_seen   = apb_rsp;
        sup_seen   = supply_en;
        led_seen   = led;
        trip_seen  = trip_out;
        gates_seen = gates;
        dout_seen  = dout;
    end

    sto_partner sto_partner_inst (.i_mclk(i_mclk), .i_level_a(lvl_a), .i_level_b(lvl_b),
        .i_stuck_supply(stuck), .i_supply_en(supply_en), .o_input_a(in_a), .o_input_b(in_b),
        .o_supply_ok(supply_ok));

    sto_monitor #(.MS_CYCLES(MS)) sto_monitor_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_apb(apb_req), .o_apb(apb_rsp), .i_torque_off_input_a(in_a), .i_torque_off_input_b(in_b),
        .i_general_input_1(gen1), .i_general_input_2(gen2), .i_driver_supply_ok(supply_ok),
        .i_voltage_fault(1'b0), .i_trip_restored(trip_in), .i_script_selftest(script_st),
        .i_pwm_gates(PWM), .o_driver_supply_en(supply_en), .o_gates(gates),
        .o_fault_dout(dout), .o_status_led(led), .o_trip_retained(trip_out));

    task complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc

    // Request held until pready is seen high at an edge
    task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge i_mclk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge i_mclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge i_mclk);
            if (rsp_seen.pready === 1'b1)
                break;
        end
        rd_data = rsp_seen.prdata;
        rd_err = rsp_seen.pslverr;
        apb_req <= '0;
        if (n == 16)
        begin
            num_errors++;
            complete_run();
        end
    endtask : xfer

    task rd_stat;
        xfer(1'b0, STAT, 32'h0);
    endtask : rd_stat

    task start_run;
        xfer(1'b1, CTRL, MON | GO);
        rd_stat();
    endtask : start_run

    initial
    begin
        int n;
        i_reset_n = 1'b0;
        apb_req = '0;
        lvl_a = 1'b1;
        lvl_b = 1'b1;
        stuck = 1'b0;
        gen1 = 1'b1;
        gen2 = 1'b1;
        trip_in = 1'b0;
        script_st = 1'b0;
        cyc(6);
        i_reset_n <= 1'b1;
        rd_stat();
        check(rd_data[BSY], 1'b1);
        xfer(1'b0, CTRL, 32'h0);
        check(rd_data, 32'h0);
        xfer(1'b0, CFG, 32'h0);
        check(rd_data, 32'h0);
        xfer(1'b0, 12'h00c, 32'h0);
        check(rd_err, 1'b1);
        check(rd_data, 32'h0);
        cyc(12 * MS);
        rd_stat();
        check(rd_data[BSY], 1'b0);
        check(rd_data[STF], 1'b0);
        start_run();
        check(rd_data[RUN], 1'b1);
        check(gates_seen, PWM);
        // One contact open: cut, then a mismatch
        lvl_a <= 1'b0;
        cyc(6);
        check(sup_seen, 1'b0);
        check(gates_seen, 6'h0);
        cyc(3 * MS);
        rd_stat();
        check(rd_data[MIS], 1'b1);
        check(rd_data[FLT], 1'b0);
        check(rd_data[RUN], 1'b0);
        check(trip_seen, 1'b1);
        lvl_a <= 1'b1;
        cyc(2 * MS);
        check(gates_seen, 6'h0);
        xfer(1'b1, CTRL, MON | CLR);
        start_run();
        check(rd_data[RUN], 1'b1);
        check(trip_seen, 1'b0);
        // Both open with the supply welded on
        xfer(1'b1, CFG, 32'h5);
        stuck <= 1'b1;
        lvl_a <= 1'b0;
        lvl_b <= 1'b0;
        cyc(3 * MS);
        rd_stat();
        check(rd_data[FLT], 1'b1);
        check(dout_seen, 8'h04);
        for (n = 0; n < 20000 && led_seen !== 1'b0; n++)
            @(posedge i_mclk);
        check(led_seen, 1'b0);
        if (n == 20000)
            complete_run();
        lvl_a <= 1'b1;
        lvl_b <= 1'b1;
        stuck <= 1'b0;
        cyc(2 * MS);
        xfer(1'b1, CTRL, MON | CLR);
        rd_stat();
        check(rd_data[FLT], 1'b0);
        check(dout_seen, 8'h00);
        // Monitoring switched off
        xfer(1'b1, CTRL, 32'h0);
        stuck <= 1'b1;
        lvl_a <= 1'b0;
        lvl_b <= 1'b0;
        cyc(3 * MS);
        rd_stat();
        check(rd_data[FLT], 1'b0);
        lvl_a <= 1'b1;
        lvl_b <= 1'b1;
        cyc(2 * MS);
        script_st <= 1'b1;
        cyc(1);
        script_st <= 1'b0;
        cyc(12 * MS);
        rd_stat();
        check(rd_data[STF], 1'b1);
        check(dout_seen, 8'h04);
        stuck <= 1'b0;
        xfer(1'b1, CTRL, CLR);
        xfer(1'b1, CTRL, TEST);
        cyc(12 * MS);
        rd_stat();
        check(rd_data[STF], 1'b0);
        // General inputs stand in for the pair
        xfer(1'b1, CFG, 32'h10);
        start_run();
        check(rd_data[RUN], 1'b1);
        lvl_b <= 1'b0;
        cyc(6);
        check(sup_seen, 1'b1);
        lvl_b <= 1'b1;
        gen1 <= 1'b0;
        cyc(6);
        check(sup_seen, 1'b0);
        gen1 <= 1'b1;
        cyc(MS);
        xfer(1'b1, CFG, 32'h0);
        // Retained trip survives a power cycle
        trip_in <= 1'b1;
        i_reset_n <= 1'b0;
        cyc(3);
        i_reset_n <= 1'b1;
        cyc(MS / 2);
        trip_in <= 1'b0;
        cyc(2 * MS);
        check(trip_seen, 1'b1);
        complete_run();
    end
endmodule : sto_monitor_bench

// ### test/sto_monitor_sva.sv
// Port checker for the torque-off monitor, bound to the top module.
// Assumes one clock domain and an APB slave with no wait states.
`timescale 1ns/100ps
module sto_monitor_sva #(
    parameter int N_GATES = 6,
    parameter int N_DOUT  = 8
) (
    input wire logic               i_mclk,
    input wire logic               i_reset_n,
    input wire sto_pkg::apb_req_s  i_apb,
    input wire sto_pkg::apb_rsp_s  o_apb,
    input wire logic               i_torque_off_input_a,
    input wire logic               i_torque_off_input_b,
    input wire logic               i_general_input_1,
    input wire logic               i_general_input_2,
    input wire logic               o_driver_supply_en,
    input wire logic [N_GATES-1:0] o_gates,
    input wire logic [N_DOUT-1:0]  o_fault_dout,
    input wire logic               o_trip_retained
);
    logic use_gen, out_en, armed, wr_ok, mapped, cut_now;

    assign wr_ok   = i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite;
    assign mapped  = i_apb.paddr inside {sto_pkg::CTRL_OFFSET, sto_pkg::CONFIG_OFFSET, sto_pkg::STATUS_OFFSET};
    assign cut_now = use_gen ? !(i_general_input_1 && i_general_input_2)
                             : !(i_torque_off_input_a && i_torque_off_input_b);

    // Shadow of config and of the last start; a start only arms, it may still be refused
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            use_gen <= 1'b0;
            out_en  <= 1'b0;
            armed   <= 1'b0;
        end
        else
        begin
            if (wr_ok && i_apb.paddr == sto_pkg::CONFIG_OFFSET)
            begin
                use_gen <= i_apb.pwdata[sto_pkg::CFG_GENERAL_BIT];
                out_en  <= i_apb.pwdata[sto_pkg::CFG_OUT_EN_BIT];
            end
            if (wr_ok && i_apb.paddr == sto_pkg::CTRL_OFFSET && i_apb.pwdata[sto_pkg::CTRL_START_BIT])
                armed <= 1'b1;
            else if (!o_driver_supply_en)
                armed <= 1'b0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    AST_SUPPLY_CUT: assert property (cut_now |-> ##3 !o_driver_supply_en)
        else $error("driver supply still enabled after input low");
    AST_GATES_STOP: assert property (cut_now |-> ##3 (o_gates == '0))
        else $error("gates still driven after input low");
    AST_NO_RESTART: assert property ((o_gates != '0) |-> armed)
        else $error("gates driven without a new start");
    AST_DOUT_QUIET: assert property (!out_en && $past(!out_en) |-> (o_fault_dout == '0))
        else $error("fault output active while disabled");
    AST_TRIP_SET: assert property (cut_now |-> ##[2:4] o_trip_retained)
        else $error("trip latch not set after input low");
    AST_READY_NEXT: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
        else $error("no ready in first access cycle");
    AST_IDLE_QUIET: assert property (!o_apb.pready |-> (o_apb.prdata == '0) && !o_apb.pslverr)
        else $error("read data or error outside access cycle");
    AST_UNMAPPED: assert property (i_apb.psel && !i_apb.penable && !mapped |=> o_apb.pslverr && o_apb.prdata == '0)
        else $error("unmapped access without error");
endmodule : sto_monitor_sva

bind sto_monitor sto_monitor_sva #(.N_GATES(N_GATES), .N_DOUT(N_DOUT)) sto_monitor_sva_inst (
    .i_mclk, .i_reset_n, .i_apb, .o_apb, .i_torque_off_input_a, .i_torque_off_input_b,
    .i_general_input_1, .i_general_input_2, .o_driver_supply_en, .o_gates, .o_fault_dout,
    .o_trip_retained);

// ### test/sto_partner.sv
// Model of the external safety switch pair and the driver supply sense.
// Assumes the bench commands switch levels and a welded supply fault.
`timescale 1ns/100ps
module sto_partner (
    input  wire logic i_mclk,
    input  wire logic i_level_a,
    input  wire logic i_level_b,
    input  wire logic i_stuck_supply,
    input  wire logic i_supply_en,
    output logic      o_input_a = 1'b1,
    output logic      o_input_b = 1'b1,
    output logic      o_supply_ok = 1'b0
);
    always @(posedge i_mclk)
    begin
        o_input_a   <= i_level_a;
        o_input_b   <= i_level_b;
        // Sense lags the enable; a welded fault keeps it up
        o_supply_ok <= i_supply_en | i_stuck_supply;
    end
endmodule : sto_partner
